//--- core/mbte_pkg.sv
package mbte_pkg;

  // ----------------------------------------
  // Widths and register file layout
  // ----------------------------------------
  localparam int REG_COUNT = 32;
  localparam int DISP_W = 6;                 // Displacement field width
  localparam int IO_AW = 6;                  // I/O space address width
  localparam logic [4:0] PTR_X_LO = 5'h1A;   // Low byte of X pair
  localparam logic [4:0] PTR_Y_LO = 5'h1C;   // Low byte of Y pair
  localparam logic [4:0] PTR_Z_LO = 5'h1E;   // Low byte of Z pair
  localparam logic [4:0] REG_R0 = 5'h00;     // Default program read target

  // ----------------------------------------
  // Status flag bit positions
  // ----------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] SP_RESET = 16'h00FF;

  // ----------------------------------------
  // Decoded operations
  // ----------------------------------------
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ROTATE_RIGHT_VIA_CARRY = 5'h01, OP_ARITH_SHIFT_RIGHT = 5'h02,
    OP_NIBBLE_SWAP = 5'h03, OP_STATUS_FLAG_RAISE_BY_INDEX = 5'h04, OP_STATUS_FLAG_DROP_BY_INDEX = 5'h05,
    OP_COPY_BIT_TO_FLAG = 5'h06, OP_COPY_FLAG_TO_BIT = 5'h07, OP_COPY_REGISTER = 5'h08,
    OP_COPY_REGISTER_PAIR = 5'h09, OP_LOAD_IMMEDIATE = 5'h0A, OP_LOAD_INDIRECT = 5'h0B,
    OP_LOAD_DISPLACED = 5'h0C, OP_LOAD_DIRECT = 5'h0D, OP_MEMORY_WRITE_INDIRECT = 5'h0E,
    OP_MEMORY_WRITE_DISPLACED = 5'h0F, OP_MEMORY_WRITE_DIRECT = 5'h10, OP_PROGRAM_MEMORY_READ = 5'h11,
    OP_PROGRAM_MEMORY_READ_R0 = 5'h12, OP_PROGRAM_MEMORY_WRITE = 5'h13, OP_PORT_IN = 5'h14,
    OP_PORT_OUT = 5'h15, OP_STACK_PUSH = 5'h16, OP_STACK_POP = 5'h17, OP_SLEEP_ENTER = 5'h18,
    OP_WATCHDOG_RESTART = 5'h19, OP_DEBUG_BREAK = 5'h1A
  } mbte_op_e;

  // Pointer pair selection
  typedef enum logic [1:0] {PTR_X = 2'h0, PTR_Y = 2'h1, PTR_Z = 2'h2} mbte_ptr_e;

  // Pointer addressing mode
  typedef enum logic [1:0] {AM_PLAIN = 2'h0, AM_POST_INC = 2'h1, AM_PRE_DEC = 2'h2} mbte_amode_e;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    SQ_IDLE = 4'b0001, SQ_DM_WAIT = 4'b0010, SQ_PM_ADDR = 4'b0100, SQ_PM_DATA = 4'b1000
  } mbte_state_e;

endpackage

//--- core/mbte_core.sv
`timescale 1ns/1ps
// Behaviour
// - Rotate right through carry, one cycle, flags
// - Arithmetic shift keeps bit 7; swap nibbles
// - Flag raise sets one flag, one cycle
// - Flag drop clears one flag, one cycle
// - Register bit copies into transfer flag only
// - Transfer flag writes one register bit
// - Indirect load two cycles, optional post-increment
// - Pre-decrement load uses decremented pointer
// - Displaced load, Y/Z only, pointer kept
// - Direct load two cycles, no flags
// - Indirect write two cycles, optional post-increment
// - Pre-decrement write uses decremented pointer
// - Displaced write, Y/Z only, pointer kept
// - Direct write two cycles, no flags
// - Program read three cycles via Z
// - Push stores register in two cycles
// - Pop loads register in two cycles
// - Sleep request issues in one cycle
// - Watchdog restart issues in one cycle
// - Break only signals debug, no flags
module mbte_core (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_op_valid,
  input wire mbte_pkg::mbte_op_e i_op,
  input wire mbte_pkg::mbte_ptr_e i_ptr,
  input wire mbte_pkg::mbte_amode_e i_amode,
  input wire logic [4:0] i_rd,
  input wire logic [4:0] i_rr,
  input wire logic [2:0] i_bit,
  input wire logic [7:0] i_imm,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_dm_rdata,
  input wire logic [7:0] i_pm_rdata,
  input wire logic [7:0] i_io_rdata,
  output logic o_busy,
  output logic [7:0] o_status_flags_register,
  output logic [15:0] o_dm_addr,
  output logic [7:0] o_dm_wdata,
  output logic o_dm_re,
  output logic o_dm_we,
  output logic [15:0] o_pm_addr,
  output logic [15:0] o_pm_wdata,
  output logic o_pm_re,
  output logic o_pm_we,
  output logic [mbte_pkg::IO_AW-1:0] o_io_addr,
  output logic [7:0] o_io_wdata,
  output logic o_io_we,
  output logic o_sleep_req,
  output logic o_wdt_restart,
  output logic o_break
);
  import mbte_pkg::*;

  // ----------------------------------------
  // Storage and decode
  // ----------------------------------------
  logic [7:0] rf_q [REG_COUNT];  // Working registers, no reset: software loads them
  logic [15:0] sp_q;             // Stack pointer, post-decrement on push
  mbte_state_e state_q;          // Multi-cycle sequencer
  logic [4:0] dst_q;             // Load target held across the wait cycles
  logic acc;                     // Operation taken this cycle
  logic [7:0] src_val;           // Register named by i_rd
  logic [7:0] rr_val;            // Register named by i_rr
  logic [7:0] rot_res;
  logic [7:0] sar_res;
  mbte_ptr_e ptr_sel;            // Program memory always walks Z
  logic [4:0] ptr_idx;
  logic [15:0] ptr_val;
  logic [15:0] ptr_inc;
  logic [15:0] ptr_dec;
  logic [15:0] mem_addr;
  logic displaced;
  logic ptr_walks;               // Op may move its pointer
  logic [4:0] pair_d;            // Even-aligned pair targets
  logic [4:0] pair_s;
  logic bit_pick;                // Helpers read by checks
  logic cur_c;

  // Maps a pointer selection onto its low register
  function automatic logic [4:0] ptr_base(input mbte_ptr_e p);
    case (p)
      PTR_X: return PTR_X_LO;
      PTR_Y: return PTR_Y_LO;
      default: return PTR_Z_LO;
    endcase
  endfunction

  // Flag update shared by both right shifts
  function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic [7:0] res, input logic c);
    logic [7:0] n;
    n = f;
    n[FLAG_C] = c;
    n[FLAG_Z] = (res == 8'h00);
    n[FLAG_N] = res[7];
    n[FLAG_V] = res[7] ^ c;
    n[FLAG_S] = res[7] ^ (res[7] ^ c);
    return n;
  endfunction

  assign acc = i_op_valid && !o_busy;
  assign src_val = rf_q[i_rd];
  assign rr_val = rf_q[i_rr];
  assign cur_c = o_status_flags_register[FLAG_C];
  assign bit_pick = src_val[i_bit];
  assign rot_res = {cur_c, src_val[7:1]};
  assign sar_res = {src_val[7], src_val[7:1]};
  assign pair_d = {i_rd[4:1], 1'b0};
  assign pair_s = {i_rr[4:1], 1'b0};
  assign displaced = (i_op == OP_LOAD_DISPLACED) || (i_op == OP_MEMORY_WRITE_DISPLACED);
  assign ptr_walks = (i_op == OP_LOAD_INDIRECT) || (i_op == OP_MEMORY_WRITE_INDIRECT)
                     || (i_op == OP_PROGRAM_MEMORY_READ);

  // ----------------------------------------
  // Pointer arithmetic
  // ----------------------------------------
  // Program reads ignore i_ptr so a stray field cannot redirect them
  always_comb
  begin
    ptr_sel = i_ptr;
    if ((i_op == OP_PROGRAM_MEMORY_READ) || (i_op == OP_PROGRAM_MEMORY_READ_R0) || (i_op == OP_PROGRAM_MEMORY_WRITE))
    begin
      ptr_sel = PTR_Z;
    end
  end

  assign ptr_idx = ptr_base(ptr_sel);
  assign ptr_val = {rf_q[ptr_idx | 5'h01], rf_q[ptr_idx]};
  assign ptr_inc = ptr_val + 16'h0001;
  assign ptr_dec = ptr_val - 16'h0001;

  // Data address: decremented value for pre-decrement, offset only for Y and Z
  always_comb
  begin
    if (i_amode == AM_PRE_DEC && !displaced)
    begin
      mem_addr = ptr_dec;
    end
    else if (displaced && ptr_sel != PTR_X)
    begin
      mem_addr = ptr_val + {{(16-DISP_W){1'b0}}, i_addr[DISP_W-1:0]};
    end
    else
    begin
      mem_addr = ptr_val;
    end
  end

  // ----------------------------------------
  // Register file writes
  // ----------------------------------------
  // Single-cycle results land at the issue edge; loads land on their last cycle
  always_ff @(posedge i_core_clk)
  begin
    if (acc)
    begin
      case (i_op)
        OP_ROTATE_RIGHT_VIA_CARRY: rf_q[i_rd] <= rot_res;
        OP_ARITH_SHIFT_RIGHT: rf_q[i_rd] <= sar_res;
        OP_NIBBLE_SWAP: rf_q[i_rd] <= {src_val[3:0], src_val[7:4]};
        OP_COPY_FLAG_TO_BIT: rf_q[i_rd][i_bit] <= o_status_flags_register[FLAG_T];
        OP_COPY_REGISTER: rf_q[i_rd] <= rr_val;
        OP_COPY_REGISTER_PAIR:
        begin
          rf_q[pair_d] <= rf_q[pair_s];
          rf_q[pair_d | 5'h01] <= rf_q[pair_s | 5'h01];
        end
        OP_LOAD_IMMEDIATE: rf_q[i_rd] <= i_imm;
        OP_PORT_IN: rf_q[i_rd] <= i_io_rdata;
        default:
        begin
          // Pointer moves at issue; the address already used the right value
          if (ptr_walks && i_amode == AM_POST_INC)
          begin
            {rf_q[ptr_idx | 5'h01], rf_q[ptr_idx]} <= ptr_inc;
          end
          else if (ptr_walks && i_amode == AM_PRE_DEC && i_op != OP_PROGRAM_MEMORY_READ)
          begin
            {rf_q[ptr_idx | 5'h01], rf_q[ptr_idx]} <= ptr_dec;
          end
        end
      endcase
    end
    else if (state_q == SQ_DM_WAIT && o_dm_re)
    begin
      rf_q[dst_q] <= i_dm_rdata;
    end
    else if (state_q == SQ_PM_DATA)
    begin
      rf_q[dst_q] <= i_pm_rdata;
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // Transfers, register copies and controls leave every flag alone; the bit-to-flag copy writes T
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_status_flags_register <= FLAGS_RESET;
    end
    else if (acc)
    begin
      case (i_op)
        OP_ROTATE_RIGHT_VIA_CARRY: o_status_flags_register <= shift_flags(o_status_flags_register, rot_res, src_val[0]);
        OP_ARITH_SHIFT_RIGHT: o_status_flags_register <= shift_flags(o_status_flags_register, sar_res, src_val[0]);
        OP_STATUS_FLAG_RAISE_BY_INDEX: o_status_flags_register[i_bit] <= 1'b1;
        OP_STATUS_FLAG_DROP_BY_INDEX: o_status_flags_register[i_bit] <= 1'b0;
        OP_COPY_BIT_TO_FLAG: o_status_flags_register[FLAG_T] <= bit_pick;
        default: o_status_flags_register <= o_status_flags_register;
      endcase
    end
  end

  // ----------------------------------------
  // Stack pointer
  // ----------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      sp_q <= SP_RESET;
    end
    else if (acc && i_op == OP_STACK_PUSH)
    begin
      sp_q <= sp_q - 16'h0001;
    end
    else if (acc && i_op == OP_STACK_POP)
    begin
      sp_q <= sp_q + 16'h0001;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Busy stalls the issue port; anything offered while busy is dropped
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      state_q <= SQ_IDLE;
      o_busy <= 1'b0;
      dst_q <= REG_R0;
    end
    else
    begin
      case (state_q)
        SQ_IDLE:
        begin
          dst_q <= (i_op == OP_PROGRAM_MEMORY_READ_R0) ? REG_R0 : i_rd;
          if (acc)
          begin
            case (i_op)
              OP_LOAD_INDIRECT, OP_LOAD_DISPLACED, OP_LOAD_DIRECT, OP_STACK_POP,
              OP_MEMORY_WRITE_INDIRECT, OP_MEMORY_WRITE_DISPLACED, OP_MEMORY_WRITE_DIRECT, OP_STACK_PUSH:
              begin
                state_q <= SQ_DM_WAIT;
                o_busy <= 1'b1;
              end
              OP_PROGRAM_MEMORY_READ, OP_PROGRAM_MEMORY_READ_R0:
              begin
                state_q <= SQ_PM_ADDR;
                o_busy <= 1'b1;
              end
              default: state_q <= SQ_IDLE;
            endcase
          end
        end
        SQ_DM_WAIT:
        begin
          state_q <= SQ_IDLE;
          o_busy <= 1'b0;
        end
        SQ_PM_ADDR: state_q <= SQ_PM_DATA;
        SQ_PM_DATA:
        begin
          state_q <= SQ_IDLE;
          o_busy <= 1'b0;
        end
        default:
        begin
          state_q <= SQ_IDLE;
          o_busy <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Memory, I/O and control strobes
  // ----------------------------------------
  // Strobes last one cycle; addresses and data hold until the next access
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_dm_addr <= 16'h0000;
      o_dm_wdata <= 8'h00;
      o_dm_re <= 1'b0;
      o_dm_we <= 1'b0;
      o_pm_addr <= 16'h0000;
      o_pm_wdata <= 16'h0000;
      o_pm_re <= 1'b0;
      o_pm_we <= 1'b0;
      o_io_addr <= '0;
      o_io_wdata <= 8'h00;
      o_io_we <= 1'b0;
      o_sleep_req <= 1'b0;
      o_wdt_restart <= 1'b0;
      o_break <= 1'b0;
    end
    else
    begin
      o_dm_re <= 1'b0;
      o_dm_we <= 1'b0;
      o_pm_re <= 1'b0;
      o_pm_we <= 1'b0;
      o_io_we <= 1'b0;
      o_sleep_req <= 1'b0;
      o_wdt_restart <= 1'b0;
      o_break <= 1'b0;
      if (acc)
      begin
        case (i_op)
          OP_LOAD_INDIRECT, OP_LOAD_DISPLACED:
          begin
            o_dm_re <= 1'b1;
            o_dm_addr <= mem_addr;
          end
          OP_LOAD_DIRECT:
          begin
            o_dm_re <= 1'b1;
            o_dm_addr <= i_addr;
          end
          OP_STACK_POP:
          begin
            o_dm_re <= 1'b1;
            o_dm_addr <= sp_q + 16'h0001;
          end
          OP_MEMORY_WRITE_INDIRECT, OP_MEMORY_WRITE_DISPLACED:
          begin
            o_dm_we <= 1'b1;
            o_dm_addr <= mem_addr;
            o_dm_wdata <= rr_val;
          end
          OP_MEMORY_WRITE_DIRECT:
          begin
            o_dm_we <= 1'b1;
            o_dm_addr <= i_addr;
            o_dm_wdata <= rr_val;
          end
          OP_STACK_PUSH:
          begin
            o_dm_we <= 1'b1;
            o_dm_addr <= sp_q;
            o_dm_wdata <= rr_val;
          end
          OP_PROGRAM_MEMORY_READ, OP_PROGRAM_MEMORY_READ_R0:
          begin
            o_pm_re <= 1'b1;
            o_pm_addr <= ptr_val;
          end
          OP_PROGRAM_MEMORY_WRITE:
          begin
            o_pm_we <= 1'b1;
            o_pm_addr <= ptr_val;
            o_pm_wdata <= {rf_q[5'h01], rf_q[REG_R0]};
          end
          OP_PORT_OUT:
          begin
            o_io_we <= 1'b1;
            o_io_addr <= i_addr[IO_AW-1:0];
            o_io_wdata <= rr_val;
          end
          OP_SLEEP_ENTER: o_sleep_req <= 1'b1;
          OP_WATCHDOG_RESTART: o_wdt_restart <= 1'b1;
          OP_DEBUG_BREAK: o_break <= 1'b1;
          default: o_break <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  rotate_carry_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    acc && i_op == OP_ROTATE_RIGHT_VIA_CARRY |=> o_status_flags_register[FLAG_C] == $past(src_val[0])
      && rf_q[$past(i_rd)][7] == $past(cur_c)) else $error("rotate carry path wrong");
  shift_sign_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    acc && i_op == OP_ARITH_SHIFT_RIGHT |=> rf_q[$past(i_rd)][7:6] == {2{$past(src_val[7])}})
    else $error("arithmetic shift lost sign");
  flag_raise_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    acc && i_op == OP_STATUS_FLAG_RAISE_BY_INDEX |=> o_status_flags_register[$past(i_bit)])
    else $error("flag not raised");
  flag_drop_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    acc && i_op == OP_STATUS_FLAG_DROP_BY_INDEX |=> !o_status_flags_register[$past(i_bit)])
    else $error("flag not dropped");
  bit_flag_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    acc && i_op == OP_COPY_BIT_TO_FLAG |=> o_status_flags_register[FLAG_T] == $past(bit_pick)
      && (o_status_flags_register & 8'hBF) == ($past(o_status_flags_register) & 8'hBF))
    else $error("bit copy to flag wrong");
  load_two_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    acc && i_op == OP_LOAD_INDIRECT |=> o_busy && o_dm_re ##1 !o_busy) else $error("load not two cycles");
  write_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    acc && i_op == OP_MEMORY_WRITE_INDIRECT |=> o_dm_we ##1 !o_dm_we && !o_busy)
    else $error("write strobe wrong");
  predec_addr_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    acc && i_op == OP_LOAD_INDIRECT && i_amode == AM_PRE_DEC |=> o_dm_addr == $past(ptr_dec))
    else $error("pre-decrement address wrong");
  prog_three_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    acc && i_op == OP_PROGRAM_MEMORY_READ |=> o_busy [*2] ##1 !o_busy) else $error("program read not three cycles");
  push_addr_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    acc && i_op == OP_STACK_PUSH |=> o_dm_we && o_dm_addr == $past(sp_q) && sp_q == $past(sp_q) - 16'h0001)
    else $error("push address wrong");
  sleep_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    acc && i_op == OP_SLEEP_ENTER |=> o_sleep_req && !o_busy ##1 !o_sleep_req) else $error("sleep pulse wrong");
  cover_pop: cover property (@(posedge i_core_clk) acc && i_op == OP_STACK_POP ##2 acc);
  cover_prog: cover property (@(posedge i_core_clk) acc && i_op == OP_PROGRAM_MEMORY_READ_R0);
  cover_disp: cover property (@(posedge i_core_clk) acc && i_op == OP_LOAD_DISPLACED && i_ptr == PTR_Y);
endmodule

//--- tb/mbte_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far side: data, program and I/O space
// ----------------------------------------
module mbte_mem_model (
  input wire logic i_core_clk,
  input wire logic [15:0] i_dm_addr,
  input wire logic [7:0] i_dm_wdata,
  input wire logic i_dm_re,
  input wire logic i_dm_we,
  input wire logic [15:0] i_pm_addr,
  input wire logic i_pm_re,
  input wire logic [5:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  input wire logic i_io_we,
  input wire logic [5:0] i_io_sel,
  output logic [7:0] o_dm_rdata,
  output logic [7:0] o_pm_rdata,
  output logic [7:0] o_io_rdata
);
  logic [7:0] dm [256]; // Data space, low address byte only
  logic [7:0] io [64]; // I/O space
  logic [7:0] dm_last_q; // Last byte shown on the read bus
  logic [7:0] pm_q; // Program byte, one cycle behind its request
  logic pm_vld_q; // Program byte valid this cycle
  initial
  begin
    foreach (dm[i]) dm[i] = 8'h00;
    foreach (io[i]) io[i] = 8'h00;
    pm_vld_q = 1'b0;
    pm_q = 8'h00;
    dm_last_q = 8'h00;
  end
  // Writes land at the edge; program bytes are a fixed address pattern
  always @(posedge i_core_clk)
  begin
    if (i_dm_we)
      dm[i_dm_addr[7:0]] <= i_dm_wdata;
    if (i_dm_re)
      dm_last_q <= dm[i_dm_addr[7:0]];
    if (i_io_we)
      io[i_io_addr] <= i_io_wdata;
    pm_vld_q <= i_pm_re;
    if (i_pm_re)
      pm_q <= i_pm_addr[7:0] ^ 8'h5A;
  end
  // Idle data and program buses show the inverse, so a stale sample never matches; the I/O bus always shows its selected byte
  assign o_dm_rdata = i_dm_re ? dm[i_dm_addr[7:0]] : ~dm_last_q;
  assign o_pm_rdata = pm_vld_q ? pm_q : ~pm_q;
  assign o_io_rdata = io[i_io_sel];
endmodule

//--- tb/mcu_bit_and_transfer_exec_tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module mcu_bit_and_transfer_exec_tb_top;
  import mbte_pkg::*;
  typedef struct {mbte_op_e op; logic [7:0] k; logic [2:0] b; logic [7:0] res; logic [7:0] fl;} mbte_row_s;
  logic clk, rst, vld, busy, dre, dwe, pre, pwe, iwe, slp, wdt, brk;
  mbte_op_e op;
  mbte_ptr_e pt;
  mbte_amode_e am;
  logic [4:0] rd, rr;
  logic [2:0] bt;
  logic [7:0] k, dmr, pmr, ior, fl, dmw, iow, wd;
  logic [15:0] ad, dma, pma, pmw, wa;
  logic [5:0] ioa;
  logic [31:0] pw; // Last program write, address and word
  logic [13:0] iw; // Last port write, address and byte
  logic [3:0] n_slp = 4'h0, n_wdt = 4'h0, n_brk = 4'h0; // Control pulse counts
  int num_errors, compares, nb, nwr, n0, cyc, ex_fl;
  // Operand loaded into r16, operation on r16, stored result and flags
  mbte_row_s rows [9] = '{
    '{OP_ROTATE_RIGHT_VIA_CARRY, 8'h81, 3'h0, 8'h40, 8'h19},
    '{OP_ARITH_SHIFT_RIGHT, 8'h83, 3'h0, 8'hC1, 8'h15},
    '{OP_NIBBLE_SWAP, 8'hC1, 3'h0, 8'h1C, 8'h15},
    '{OP_COPY_BIT_TO_FLAG, 8'h1C, 3'h0, 8'h1C, 8'h15},
    '{OP_COPY_FLAG_TO_BIT, 8'hFF, 3'h7, 8'h7F, 8'h15},
    '{OP_COPY_BIT_TO_FLAG, 8'h1C, 3'h4, 8'h1C, 8'h55},
    '{OP_COPY_FLAG_TO_BIT, 8'h00, 3'h0, 8'h01, 8'h55},
    '{OP_ROTATE_RIGHT_VIA_CARRY, 8'h00, 3'h0, 8'h80, 8'h4C},
    '{OP_ARITH_SHIFT_RIGHT, 8'h01, 3'h0, 8'h00, 8'h5B}};
  mbte_core i_mbte_core (.i_core_clk(clk), .i_rst(rst), .i_op_valid(vld), .i_op(op), .i_ptr(pt),
    .i_amode(am), .i_rd(rd), .i_rr(rr), .i_bit(bt), .i_imm(k), .i_addr(ad), .i_dm_rdata(dmr),
    .i_pm_rdata(pmr), .i_io_rdata(ior), .o_busy(busy), .o_status_flags_register(fl), .o_dm_addr(dma),
    .o_dm_wdata(dmw), .o_dm_re(dre), .o_dm_we(dwe), .o_pm_addr(pma), .o_pm_wdata(pmw), .o_pm_re(pre),
    .o_pm_we(pwe), .o_io_addr(ioa), .o_io_wdata(iow), .o_io_we(iwe), .o_sleep_req(slp),
    .o_wdt_restart(wdt), .o_break(brk));
  mbte_mem_model i_mbte_mem_model (.i_core_clk(clk), .i_dm_addr(dma), .i_dm_wdata(dmw), .i_dm_re(dre),
    .i_dm_we(dwe), .i_pm_addr(pma), .i_pm_re(pre), .i_io_addr(ioa), .i_io_wdata(iow), .i_io_we(iwe),
    .i_io_sel(ad[5:0]), .o_dm_rdata(dmr), .o_pm_rdata(pmr), .o_io_rdata(ior));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Record every write and control pulse handed out; a hang past the ceiling is a failure
  always @(posedge clk)
  begin
    if (dwe)
    begin
      wa <= dma;
      wd <= dmw;
      nwr <= nwr + 1;
    end
    if (pwe)
      pw <= {pma, pmw};
    if (iwe)
      iw <= {ioa, iow};
    n_slp <= n_slp + {3'h0, slp};
    n_wdt <= n_wdt + {3'h0, wdt};
    n_brk <= n_brk + {3'h0, brk};
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] g, e);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Offer one operation, then wait out its busy cycles (counted in nb)
  task automatic go(input mbte_op_e o, input mbte_amode_e m, input mbte_ptr_e p,
                    input logic [4:0] d, s, input logic [15:0] a);
    @(posedge clk);
    vld <= 1'b1;
    op <= o;
    am <= m;
    pt <= p;
    rd <= d;
    rr <= s;
    ad <= a;
    k <= a[7:0];
    bt <= a[2:0];
    @(posedge clk);
    vld <= 1'b0;
    nb = 0;
    #1;
    while (busy === 1'b1 && nb < 8)
    begin
      @(posedge clk);
      #1;
      nb++;
    end
    @(posedge clk);
    #1;
  endtask
  task automatic ex(input mbte_op_e o, input logic [4:0] d, s, input logic [15:0] a);
    go(o, AM_PLAIN, PTR_X, d, s, a);
  endtask
  // Store and compare the address and byte seen on the data bus
  task automatic wr(input mbte_op_e o, input mbte_amode_e m, input mbte_ptr_e p, input logic [4:0] s,
                    input logic [15:0] a, ea, input logic [7:0] ed);
    go(o, m, p, 5'h00, s, a);
    chk(wa, ea);
    chk(wd, ed);
    chk(nb, 1);
  endtask
  task automatic peek(input logic [4:0] s, input logic [15:0] a, input logic [7:0] e);
    wr(OP_MEMORY_WRITE_DIRECT, AM_PLAIN, PTR_X, s, a, a, e);
  endtask
  task automatic finish_test();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    vld = 1'b0;
    op = OP_NOP;
    pt = PTR_X;
    am = AM_PLAIN;
    {rd, rr, bt, k, ad} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({busy, fl}, 9'h000);
    // Raise then drop every flag on consecutive edges
    for (int i = 0; i < 17; i++)
    begin
      @(posedge clk);
      vld <= (i < 16);
      op <= (i < 8) ? OP_STATUS_FLAG_RAISE_BY_INDEX : OP_STATUS_FLAG_DROP_BY_INDEX;
      bt <= i[2:0];
      #1;
      if (i > 0)
      begin
        ex_fl = (i < 9) ? (ex_fl | (1 << (i - 1))) : (ex_fl & ~(1 << (i - 9)));
        chk(fl, ex_fl);
      end
    end
    foreach (rows[i])
    begin
      ex(OP_LOAD_IMMEDIATE, 5'h10, 5'h00, {8'h00, rows[i].k});
      ex(rows[i].op, 5'h10, 5'h10, {13'h0000, rows[i].b});
      chk(fl, rows[i].fl);
      peek(5'h10, 16'h0040, rows[i].res);
    end
    // Pointer walks through X, then Y displaced
    ex(OP_LOAD_IMMEDIATE, 5'h1A, 5'h00, 16'h0010);
    ex(OP_LOAD_IMMEDIATE, 5'h1B, 5'h00, 16'h0000);
    ex(OP_LOAD_IMMEDIATE, 5'h11, 5'h00, 16'h001C);
    ex(OP_LOAD_IMMEDIATE, 5'h12, 5'h00, 16'h0080);
    wr(OP_MEMORY_WRITE_INDIRECT, AM_POST_INC, PTR_X, 5'h12, 16'h0000, 16'h0010, 8'h80);
    wr(OP_MEMORY_WRITE_INDIRECT, AM_PLAIN, PTR_X, 5'h11, 16'h0000, 16'h0011, 8'h1C);
    wr(OP_MEMORY_WRITE_INDIRECT, AM_PLAIN, PTR_X, 5'h11, 16'h0000, 16'h0011, 8'h1C);
    go(OP_LOAD_INDIRECT, AM_PRE_DEC, PTR_X, 5'h16, 5'h00, 16'h0000);
    chk(nb, 1);
    peek(5'h16, 16'h0050, 8'h80);
    wr(OP_MEMORY_WRITE_INDIRECT, AM_PRE_DEC, PTR_X, 5'h11, 16'h0000, 16'h000F, 8'h1C);
    go(OP_LOAD_INDIRECT, AM_POST_INC, PTR_X, 5'h17, 5'h00, 16'h0000);
    chk(nb, 1);
    go(OP_LOAD_INDIRECT, AM_PLAIN, PTR_X, 5'h18, 5'h00, 16'h0000);
    peek(5'h17, 16'h0051, 8'h1C);
    peek(5'h18, 16'h0052, 8'h80);
    ex(OP_LOAD_IMMEDIATE, 5'h1C, 5'h00, 16'h0020);
    ex(OP_LOAD_IMMEDIATE, 5'h1D, 5'h00, 16'h0000);
    wr(OP_MEMORY_WRITE_DISPLACED, AM_PLAIN, PTR_Y, 5'h11, 16'h0003, 16'h0023, 8'h1C);
    wr(OP_MEMORY_WRITE_INDIRECT, AM_PLAIN, PTR_Y, 5'h12, 16'h0000, 16'h0020, 8'h80);
    go(OP_LOAD_DISPLACED, AM_PLAIN, PTR_Y, 5'h19, 5'h00, 16'h0003);
    peek(5'h19, 16'h0053, 8'h1C);
    ex(OP_LOAD_DIRECT, 5'h15, 5'h00, 16'h0010);
    chk(nb, 1);
    peek(5'h15, 16'h0054, 8'h80);
    // Stack grows down from its reset top
    wr(OP_STACK_PUSH, AM_PLAIN, PTR_X, 5'h11, 16'h0000, 16'h00FF, 8'h1C);
    wr(OP_STACK_PUSH, AM_PLAIN, PTR_X, 5'h12, 16'h0000, 16'h00FE, 8'h80);
    ex(OP_STACK_POP, 5'h14, 5'h00, 16'h0000);
    chk(nb, 1);
    ex(OP_STACK_POP, 5'h13, 5'h00, 16'h0000);
    peek(5'h14, 16'h0055, 8'h80);
    peek(5'h13, 16'h0056, 8'h1C);
    // Program space through Z = 5, then the port and control pulses
    ex(OP_LOAD_IMMEDIATE, 5'h1E, 5'h00, 16'h0005);
    ex(OP_LOAD_IMMEDIATE, 5'h1F, 5'h00, 16'h0000);
    go(OP_PROGRAM_MEMORY_READ, AM_POST_INC, PTR_Z, 5'h02, 5'h00, 16'h0000);
    chk(nb, 2);
    go(OP_PROGRAM_MEMORY_READ_R0, AM_PLAIN, PTR_Z, 5'h02, 5'h00, 16'h0000);
    peek(5'h02, 16'h0057, 8'h5F);
    peek(5'h00, 16'h0058, 8'h5C);
    ex(OP_COPY_REGISTER, 5'h01, 5'h11, 16'h0000);
    ex(OP_PROGRAM_MEMORY_WRITE, 5'h00, 5'h00, 16'h0000);
    chk(pw, 32'h00061C5C);
    ex(OP_COPY_REGISTER_PAIR, 5'h04, 5'h00, 16'h0000);
    peek(5'h05, 16'h0059, 8'h1C);
    ex(OP_PORT_OUT, 5'h00, 5'h12, 16'h0005);
    chk(iw, 14'h0580);
    ex(OP_PORT_IN, 5'h03, 5'h00, 16'h0005);
    peek(5'h03, 16'h005A, 8'h80);
    ex(OP_SLEEP_ENTER, 5'h00, 5'h00, 16'h0000);
    ex(OP_WATCHDOG_RESTART, 5'h00, 5'h00, 16'h0000);
    ex(OP_DEBUG_BREAK, 5'h00, 5'h00, 16'h0000);
    chk({n_slp, n_wdt, n_brk, fl, busy}, 21'h222B6);
    // A second offer during the busy cycle must be dropped
    n0 = nwr;
    @(posedge clk);
    vld <= 1'b1;
    op <= OP_MEMORY_WRITE_DIRECT;
    ad <= 16'h0060;
    @(posedge clk);
    ad <= 16'h0061;
    @(posedge clk);
    vld <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(nwr - n0, 32'h1);
    chk(wa, 16'h0060);
    // Reset in mid-run clears the flags again
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({busy, fl}, 9'h000);
    finish_test();
  end
endmodule
